// File: fcp_pkg.sv
// Constants, types and register map of the four-channel modulator
package fcp_pkg;
	localparam int AW = 10;
	localparam int DW = 16;
	localparam int BW = 8;
	localparam int NREG = 10;
	// Register indexes; byte address is four times the index
	localparam logic [7:0] IDX_DUTY0 = 8'h90;
	localparam logic [7:0] IDX_CYC0 = 8'h94;
	localparam logic [7:0] IDX_CNT0 = 8'h96;
	localparam logic [7:0] IDX_CTRL_A = 8'h98;
	localparam logic [7:0] IDX_SPEED = 8'h99;
	// Reset values
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [7:0] CTRL_A_RST = 8'h00;
	localparam logic [7:0] SPEED_RST = 8'hFE;
	// Time-base prescaler last counts for the half and quarter rates
	localparam logic [1:0] TB_HALF_LAST = 2'h1;
	localparam logic [1:0] TB_QUARTER_LAST = 2'h3;
	// Counter clock select codes
	typedef enum logic [1:0] {CKS_CORE, CKS_TB_HALF, CKS_TB_QUARTER, CKS_ALT} fcp_cks_type;
	// Control register A fields, bit 7 down to bit 0
	typedef struct packed {
		logic irq1_cause_sel;
		fcp_cks_type clk_sel_1;
		logic run_counter_1;
		logic irq0_cause_sel;
		fcp_cks_type clk_sel_0;
		logic run_counter_0;
	} fcp_ctrl_type;
	// Register port request
	typedef struct packed {
		logic [AW-1:0] addr;
		logic [DW-1:0] wdata;
		logic wr;
		logic rd;
		logic wide;
	} fcp_bus_req_type;
endpackage : fcp_pkg

// File: fcp_counter.sv
// Reloading up-counter shared by two channels
`timescale 1ns/1ps
module fcp_counter #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Count control
	input wire logic tick,
	input wire logic run,
	// Software load
	input wire logic load,
	input wire logic [W-1:0] load_val,
	input wire logic [W-1:0] cycle,
	// Count state
	output logic [W-1:0] cnt_q,
	output logic ovf
);
	logic full;

	// All ones means the next tick wraps
	assign full = &cnt_q;
	assign ovf = tick & run & full;

	// Load, reload on wrap, else count up
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= W'(fcp_pkg::BYTE_RST);
		end else if (load) begin
			cnt_q <= load_val;
		end else if (ovf) begin
			cnt_q <= cycle;
		end else if (tick & run) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end
endmodule : fcp_counter

// File: fcp_pwm_top.sv
// Four-channel modulator: registers, clock select, counters, outputs
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
module fcp_pwm_top (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Register port
	input wire fcp_pkg::fcp_bus_req_type bus_req,
	output logic [15:0] rd_data,
	// Count sources, one-cycle ticks from local logic
	input wire logic timebase_clock,
	input wire logic timer_nine,
	// Waveform pins, bit n is channel n
	output logic [3:0] wave_out,
	// Interrupt request pulses
	output logic [3:0] irq_req
);
	localparam int NR = fcp_pkg::NREG;
	logic [7:0] idx;
	logic [7:0] duty_q [4];
	logic [7:0] cyc_q [2];
	fcp_pkg::fcp_ctrl_type ctrl_q;
	logic high_speed_sel_q;
	logic [15:0] rd_data_q;
	logic [3:0] wave_q;
	logic [3:0] irq_q;
	logic [1:0] pre_q;
	logic [NR-1:0] we;
	logic [NR-1:0] pair_hit;
	logic [7:0] wb [NR];
	logic [7:0] rb [NR];
	logic [7:0] cnt0;
	logic [7:0] cnt1;
	logic ovf0;
	logic ovf1;
	logic casc;
	logic hs;
	logic run0e;
	logic run1e;
	logic tick0;
	logic tick1;
	logic c0_tick;
	logic c1_tick;
	logic [15:0] pwc16;
	logic [3:0] ch_run;
	logic [3:0] ch_match;
	logic [3:0] ch_ovf;

	// Word index from byte address
	assign idx = bus_req.addr[9:2];

	// Per-register write enables and byte lanes
	for (genvar k = 0; k < NR; k++) begin : g_wr
		localparam logic [7:0] IK = fcp_pkg::IDX_DUTY0 + 8'(k);
		if ((k % 2 == 1) && (k < 8)) begin : g_pair
			assign pair_hit[k] = bus_req.wide & (idx == IK - 8'h01);
		end else begin : g_single
			assign pair_hit[k] = 1'b0;
		end
		assign we[k] = bus_req.wr & ((idx == IK) | pair_hit[k]);
		assign wb[k] = pair_hit[k] ? bus_req.wdata[15:8] : bus_req.wdata[7:0];
	end

	// Duty registers
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < 4; i++) begin
				duty_q[i] <= fcp_pkg::BYTE_RST;
			end
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (we[i]) begin
					duty_q[i] <= wb[i];
				end
			end
		end
	end

	// Cycle registers, also loaded by a counter write
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cyc_q[0] <= fcp_pkg::BYTE_RST;
			cyc_q[1] <= fcp_pkg::BYTE_RST;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (we[6+i]) begin
					cyc_q[i] <= wb[6+i];
				end else if (we[4+i]) begin
					cyc_q[i] <= wb[4+i];
				end
			end
		end
	end

	// Control register A and speed select
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ctrl_q <= fcp_pkg::fcp_ctrl_type'(fcp_pkg::CTRL_A_RST);
			high_speed_sel_q <= fcp_pkg::SPEED_RST[0];
		end else begin
			if (we[8]) begin
				ctrl_q <= fcp_pkg::fcp_ctrl_type'(wb[8]);
			end
			if (we[9]) begin
				high_speed_sel_q <= wb[9][0];
			end
		end
	end

	// Readback bytes
	assign rb[0] = duty_q[0];
	assign rb[1] = duty_q[1];
	assign rb[2] = duty_q[2];
	assign rb[3] = duty_q[3];
	assign rb[4] = cyc_q[0];
	assign rb[5] = cyc_q[1];
	assign rb[6] = cnt0;
	assign rb[7] = cnt1;
	assign rb[8] = ctrl_q;
	assign rb[9] = {fcp_pkg::SPEED_RST[7:1], high_speed_sel_q};

	// Read data one cycle after the strobe, zero otherwise
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rd_data_q <= 16'h0000;
		end else begin
			rd_data_q <= 16'h0000;
			if (bus_req.rd) begin
				for (int k = 0; k < NR; k++) begin
					if (idx == fcp_pkg::IDX_DUTY0 + 8'(k)) begin
						rd_data_q[7:0] <= rb[k];
					end
					if ((k % 2 == 1) && (k < 8) && bus_req.wide
						&& (idx == fcp_pkg::IDX_DUTY0 + 8'(k - 1))) begin
						rd_data_q[15:8] <= rb[k];
					end
				end
			end
		end
	end
	assign rd_data = rd_data_q;

	// Time-base prescaler for the half and quarter rates
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pre_q <= 2'h0;
		end else if (timebase_clock) begin
			pre_q <= pre_q + 2'h1;
		end
	end

	// Count tick for one clock select code
	function automatic logic sel_tick(fcp_pkg::fcp_cks_type cks, logic alt, logic tb,
			logic [1:0] pre);
		logic t;
		t = 1'b0;
		case (cks)
			fcp_pkg::CKS_CORE: t = 1'b1;
			fcp_pkg::CKS_TB_HALF: t = tb & (pre[0] == fcp_pkg::TB_HALF_LAST[0]);
			fcp_pkg::CKS_TB_QUARTER: t = tb & (pre == fcp_pkg::TB_QUARTER_LAST);
			default: t = alt;
		endcase
		return t;
	endfunction : sel_tick

	// Mode and clock routing
	assign casc = (ctrl_q.clk_sel_1 == fcp_pkg::CKS_ALT);
	assign hs = casc & high_speed_sel_q;
	assign run0e = hs ? ctrl_q.run_counter_1 : ctrl_q.run_counter_0;
	assign run1e = ctrl_q.run_counter_1;
	assign tick0 = sel_tick(ctrl_q.clk_sel_0, timer_nine, timebase_clock, pre_q);
	assign tick1 = sel_tick(ctrl_q.clk_sel_1, 1'b0, timebase_clock, pre_q);
	// High speed: upper byte counts fast, its wrap steps the lower byte
	assign c0_tick = hs ? (tick0 & run1e & (&cnt1)) : tick0;
	assign c1_tick = hs ? tick0 : (casc ? (tick0 & run0e & (&cnt0)) : tick1);

	// Counter 0
	fcp_counter #(.W(fcp_pkg::BW)) u_up_counter_0 (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.tick(c0_tick),
		.run(run0e),
		.load(we[6]),
		.load_val(wb[6]),
		.cycle(cyc_q[0]),
		.cnt_q(cnt0),
		.ovf(ovf0)
	);

	// Counter 1
	fcp_counter #(.W(fcp_pkg::BW)) u_up_counter_1 (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.tick(c1_tick),
		.run(run1e),
		.load(we[7]),
		.load_val(wb[7]),
		.cycle(cyc_q[1]),
		.cnt_q(cnt1),
		.ovf(ovf1)
	);

	assign pwc16 = {cnt1, cnt0};

	// Per-channel run, match and wrap events
	for (genvar c = 0; c < 4; c++) begin : g_ch
		if (c % 2 == 0) begin : g_even
			assign ch_run[c] = run0e;
			assign ch_match[c] = c0_tick & run0e & (cnt0 == duty_q[c]);
			assign ch_ovf[c] = ovf0;
		end else begin : g_odd
			logic [15:0] duty16;
			assign duty16 = {duty_q[c], duty_q[c-1]};
			assign ch_run[c] = casc ? (run0e & run1e) : run1e;
			assign ch_match[c] = casc ? (c0_tick & run0e & (pwc16 == duty16))
				: (c1_tick & run1e & (cnt1 == duty_q[c]));
			assign ch_ovf[c] = hs ? ovf0 : ovf1;

			// Output flip-flop of an odd channel
			always_ff @(posedge clk_sys or negedge nrst) begin
				if (!nrst) begin
					wave_q[c] <= 1'b1;
				end else if (!ch_run[c]) begin
					wave_q[c] <= 1'b1;
				end else if (hs) begin
					wave_q[c] <= (pwc16 <= duty16);
				end else if (ch_ovf[c]) begin
					wave_q[c] <= 1'b1;
				end else if (ch_match[c]) begin
					wave_q[c] <= 1'b0;
				end
			end
		end
		if (c % 2 == 0) begin : g_even_out
			// Output flip-flop of an even channel
			always_ff @(posedge clk_sys or negedge nrst) begin
				if (!nrst) begin
					wave_q[c] <= 1'b1;
				end else if (!ch_run[c]) begin
					wave_q[c] <= 1'b1;
				end else if (ch_ovf[c]) begin
					wave_q[c] <= 1'b1;
				end else if (ch_match[c]) begin
					wave_q[c] <= 1'b0;
				end
			end
		end
	end
	assign wave_out = wave_q;

	// Interrupt requests, cause selectable on requests 0 and 1, match only on 2 and 3
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			irq_q <= 4'h0;
		end else begin
			irq_q[0] <= ctrl_q.irq0_cause_sel ? ovf0 : ch_match[0];
			irq_q[1] <= ctrl_q.irq1_cause_sel ? ch_ovf[1] : ch_match[1];
			irq_q[2] <= ch_match[2];
			irq_q[3] <= ch_match[3];
		end
	end
	assign irq_req = irq_q;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	// Checks on the register file
	a_ctrl_a_store: assert property (bus_req.wr && !bus_req.wide
		&& idx == fcp_pkg::IDX_CTRL_A |=> ctrl_q == $past(bus_req.wdata[7:0]))
		else $error("control A write lost");
	a_speed_ones: assert property (bus_req.rd && idx == fcp_pkg::IDX_SPEED
		|=> rd_data[7:1] == 7'h7F && rd_data[15:8] == 8'h00)
		else $error("speed register upper bits not one");
	a_duty_pair: assert property (bus_req.wr && bus_req.wide
		&& idx == fcp_pkg::IDX_DUTY0
		|=> duty_q[1] == $past(bus_req.wdata[15:8]) && duty_q[0] == $past(bus_req.wdata[7:0]))
		else $error("wide duty write misplaced");
	a_cnt_cycle: assert property (bus_req.wr && !bus_req.wide
		&& idx == fcp_pkg::IDX_CNT0 |=> cyc_q[0] == cnt0 && cnt0 == $past(bus_req.wdata[7:0]))
		else $error("counter write did not load cycle");

	// Checks on counting
	a_halt_zero: assert property (!run0e && !we[6] |=> $stable(cnt0))
		else $error("counter 0 moved while halted");
	a_halt_one: assert property (!run1e && !we[7] |=> $stable(cnt1))
		else $error("counter 1 moved while halted");
	a_reload_zero: assert property (ovf0 && !we[6] |=> cnt0 == $past(cyc_q[0]))
		else $error("counter 0 did not reload");
	a_core_tick: assert property (ctrl_q.clk_sel_0 == fcp_pkg::CKS_CORE && !hs
		&& run0e && !we[6] && cnt0 != 8'hFF |=> cnt0 == $past(cnt0) + 8'h01)
		else $error("core clock select did not count");

	// Checks on outputs and requests
	a_idle_high: assert property (!ch_run[0] |=> wave_out[0])
		else $error("idle channel 0 not high");
	a_match_low: assert property (ch_match[0] && !ch_ovf[0] && run0e
		|=> !wave_out[0] && irq_req[0] == !$past(ctrl_q.irq0_cause_sel))
		else $error("duty match did not clear output");
	a_irq_cause: assert property (ctrl_q.irq0_cause_sel && ovf0 |=> irq_req[0])
		else $error("overflow cause not requested");
	a_irq_one: assert property (!ctrl_q.irq1_cause_sel && ch_match[1] |=> irq_req[1])
		else $error("match cause not requested");

	// Checks on further register writes
	a_cycle_write: assert property (bus_req.wr && !bus_req.wide
		&& idx == fcp_pkg::IDX_CYC0 |=> cyc_q[0] == $past(bus_req.wdata[7:0]))
		else $error("cycle register write lost");
	a_speed_store: assert property (bus_req.wr && idx == fcp_pkg::IDX_SPEED
		|=> high_speed_sel_q == $past(bus_req.wdata[0]))
		else $error("speed select write lost");
	a_duty_byte: assert property (bus_req.wr && !bus_req.wide
		&& idx == fcp_pkg::IDX_DUTY0 + 8'h02 |=> duty_q[2] == $past(bus_req.wdata[7:0]))
		else $error("duty 2 byte write lost");
	a_cnt_one: assert property (bus_req.wr && !bus_req.wide
		&& idx == fcp_pkg::IDX_CNT0 + 8'h01
		|=> cyc_q[1] == cnt1 && cnt1 == $past(bus_req.wdata[7:0]))
		else $error("counter 1 write did not load cycle");
	a_cnt_pair: assert property (bus_req.wr && bus_req.wide
		&& idx == fcp_pkg::IDX_CNT0
		|=> cyc_q[1] == cnt1 && cnt1 == $past(bus_req.wdata[15:8]))
		else $error("wide counter write did not load cycle 1");

	// Checks on cascade and high speed
	a_cascade_step: assert property (casc && !hs && c0_tick && run0e && cnt0 == 8'hFF
		&& run1e && cnt1 != 8'hFF && !we[7] |=> cnt1 == $past(cnt1) + 8'h01)
		else $error("cascade did not step counter 1");
	a_speed_wave: assert property (hs && ch_run[1]
		|=> wave_out[1] == ($past(pwc16) <= {$past(duty_q[1]), $past(duty_q[0])}))
		else $error("high speed output wrong");

	// Checks on further requests, wrap and idle levels
	a_irq_two: assert property (ch_match[2] |=> irq_req[2])
		else $error("duty 2 match not requested");
	a_irq_three: assert property (ch_match[3] |=> irq_req[3])
		else $error("duty 3 match not requested");
	a_wrap_high: assert property (ch_ovf[0] && ch_run[0] |=> wave_out[0])
		else $error("wrap did not set output 0");
	a_idle_odd: assert property (!ch_run[1] |=> wave_out[1])
		else $error("idle channel 1 not high");
	a_idle_even: assert property (!ch_run[2] |=> wave_out[2])
		else $error("idle channel 2 not high");
	a_rd_quiet: assert property (!bus_req.rd |=> rd_data == 16'h0000)
		else $error("read data stood too long");

	// Main scenarios
	c_wrap_zero: cover property (ovf0 ##1 wave_out[0]);
	c_cascade: cover property (casc && !hs && ovf1);
	c_high_speed: cover property (hs && wave_out[1] ##1 !wave_out[1]);
	c_match_one: cover property (ch_match[1] ##1 !wave_out[1]);
	c_wide_read: cover property (bus_req.rd && bus_req.wide ##1 rd_data[15:8] != 8'h00);
endmodule : fcp_pwm_top

// File: tb.sv
// Self-checking bench for the four-channel modulator
`timescale 1ns/1ps
module tb;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	fcp_pkg::fcp_bus_req_type bus_req = '0;
	logic [15:0] rd_data;
	logic timebase_clock = 1'b0;
	logic timer_nine = 1'b0;
	logic [3:0] wave_out;
	logic [3:0] irq_req;
	logic [2:0] t5_q = 3'h0;
	logic [7:0] c;
	int n_errors = 0;
	int num_checks = 0;
	int hi[4];
	int irqs[4];
	int per;
	int p0[4] = '{4, 16, 32, 20};
	int p1[4] = '{4, 16, 32, 8};

	fcp_pwm_top i_fcp_pwm_top (.clk_sys(clk_sys), .nrst(nrst), .bus_req(bus_req),
		.rd_data(rd_data), .timebase_clock(timebase_clock), .timer_nine(timer_nine),
		.wave_out(wave_out), .irq_req(irq_req));

	// Clock
	always #5 clk_sys = ~clk_sys;

	// Tick sources: time base every 2nd cycle, timer every 5th
	always @(posedge clk_sys) begin
		timebase_clock <= ~timebase_clock;
		t5_q <= (t5_q == 3'h4) ? 3'h0 : t5_q + 3'h1;
		timer_nine <= (t5_q == 3'h4);
	end

	// Compare and count
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// One-cycle write strobe
	task automatic bus_wr(input logic [7:0] idx, input logic [15:0] v, input logic w);
		@(posedge clk_sys);
		bus_req <= '{addr: {idx, 2'b00}, wdata: v, wr: 1'b1, rd: 1'b0, wide: w};
		@(posedge clk_sys);
		bus_req.wr <= 1'b0;
	endtask : bus_wr

	// One-cycle read strobe, data taken in the following cycle
	task automatic rd_chk(input logic [7:0] idx, input logic w, input logic [15:0] exp,
		input string what);
		@(posedge clk_sys);
		bus_req <= '{addr: {idx, 2'b00}, wdata: 16'h0000, wr: 1'b0, rd: 1'b1, wide: w};
		@(posedge clk_sys);
		bus_req.rd <= 1'b0;
		#1;
		check(what, rd_data, exp);
	endtask : rd_chk

	// Count high and request cycles per channel
	task automatic watch(input int n);
		hi = '{0, 0, 0, 0};
		irqs = '{0, 0, 0, 0};
		repeat (n) begin
			@(posedge clk_sys);
			#1;
			for (int i = 0; i < 4; i++) begin
				hi[i] += (wave_out[i] === 1'b1);
				irqs[i] += (irq_req[i] === 1'b1);
			end
		end
	endtask : watch

	// Cycles between two request pulses, bounded
	task automatic meas(input int i);
		int k;
		k = 0;
		per = 0;
		while (irq_req[i] !== 1'b1 && k < 100) begin
			@(posedge clk_sys);
			#1;
			k++;
		end
		do begin
			@(posedge clk_sys);
			#1;
			per++;
		end while (irq_req[i] !== 1'b1 && per < 100);
	endtask : meas

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : give_verdict

	// Hang guard
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_errors++;
		$display("watchdog expired");
		give_verdict();
	end

	// Main sequence
	initial begin
		repeat (5) @(posedge clk_sys);
		nrst <= 1'b1;
		#1;
		check("idle waves", {12'h000, wave_out}, 16'h000F);
		check("idle irq", {12'h000, irq_req}, 16'h0000);
		for (int i = 0; i < 11; i++) begin
			c = fcp_pkg::IDX_DUTY0 + 8'(i);
			rd_chk(c, 1'b0, (c == fcp_pkg::IDX_SPEED) ? 16'h00FE : 16'h0000, "reset");
		end
		$display("test reset done");
		for (int i = 0; i < 6; i++) begin
			bus_wr(fcp_pkg::IDX_DUTY0 + 8'(i), 16'h0031 + 16'(i), 1'b0);
		end
		for (int i = 0; i < 6; i++) begin
			rd_chk(fcp_pkg::IDX_DUTY0 + 8'(i), 1'b0, 16'h0031 + 16'(i), "byte reg");
		end
		bus_wr(fcp_pkg::IDX_CTRL_A, 16'h00EE, 1'b0);
		rd_chk(fcp_pkg::IDX_CTRL_A, 1'b0, 16'h00EE, "control a");
		bus_wr(fcp_pkg::IDX_CNT0, 16'h0010, 1'b0);
		rd_chk(fcp_pkg::IDX_CYC0, 1'b0, 16'h0010, "cycle load");
		bus_wr(fcp_pkg::IDX_SPEED, 16'h0000, 1'b0);
		rd_chk(fcp_pkg::IDX_SPEED, 1'b0, 16'h00FE, "speed zero");
		bus_wr(fcp_pkg::IDX_SPEED, 16'h0001, 1'b0);
		rd_chk(fcp_pkg::IDX_SPEED, 1'b0, 16'h00FF, "speed one");
		bus_wr(fcp_pkg::IDX_SPEED, 16'h0000, 1'b0);
		bus_wr(8'h9A, 16'h00FF, 1'b0);
		rd_chk(8'h9A, 1'b0, 16'h0000, "unmapped");
		bus_wr(fcp_pkg::IDX_DUTY0, 16'hA55A, 1'b1);
		rd_chk(fcp_pkg::IDX_DUTY0 + 8'h01, 1'b0, 16'h00A5, "pair upper");
		rd_chk(fcp_pkg::IDX_DUTY0, 1'b1, 16'hA55A, "pair wide");
		$display("test registers done");
		// Every clock code, overflow cause, on both counters
		for (int s = 0; s < 4; s++) begin
			bus_wr(fcp_pkg::IDX_CNT0, 16'h00FC, 1'b0);
			bus_wr(fcp_pkg::IDX_CTRL_A, 16'h0009 | 16'(s << 1), 1'b0);
			meas(0);
			check("period 0", 16'(per), 16'(p0[s]));
			bus_wr(fcp_pkg::IDX_CNT0, 16'h00FE, 1'b0);
			bus_wr(fcp_pkg::IDX_CNT0 + 8'h01, 16'h00FC, 1'b0);
			bus_wr(fcp_pkg::IDX_CTRL_A, 16'h0090 | 16'(s << 5) | 16'(s == 3), 1'b0);
			meas(1);
			check("period 1", 16'(per), 16'(p1[s]));
			bus_wr(fcp_pkg::IDX_CTRL_A, 16'h0000, 1'b0);
		end
		$display("test clock select done");
		// Duty waveforms on all four channels
		bus_wr(fcp_pkg::IDX_CNT0, 16'h00FC, 1'b0);
		bus_wr(fcp_pkg::IDX_CNT0 + 8'h01, 16'h00FC, 1'b0);
		bus_wr(fcp_pkg::IDX_DUTY0, 16'hFEFD, 1'b1);
		bus_wr(fcp_pkg::IDX_DUTY0 + 8'h02, 16'hFDFE, 1'b1);
		// Pins are taken as set to direction out and alternate function
		bus_wr(fcp_pkg::IDX_CTRL_A, 16'h0011, 1'b0);
		repeat (8) @(posedge clk_sys);
		watch(40);
		for (int i = 0; i < 4; i++) begin
			check("high cycles", 16'(hi[i]), (i == 0 || i == 3) ? 16'h0014 : 16'h001E);
			check("match irqs", 16'(irqs[i]), 16'h000A);
		end
		bus_wr(fcp_pkg::IDX_DUTY0, 16'h0000, 1'b0);
		repeat (4) @(posedge clk_sys);
		watch(40);
		check("no match irq", 16'(irqs[0]), 16'h0000);
		$display("test duty done");
		// Halt both counters
		bus_wr(fcp_pkg::IDX_CTRL_A, 16'h0000, 1'b0);
		repeat (2) @(posedge clk_sys);
		watch(20);
		check("halted waves", 16'(hi[0] + hi[1] + hi[2] + hi[3]), 16'h0050);
		check("halted irqs", 16'(irqs[0] + irqs[1] + irqs[2] + irqs[3]), 16'h0000);
		$display("test halt done");
		// High speed: run bit 1 alone drives the cascaded pair
		bus_wr(fcp_pkg::IDX_CNT0, 16'hFCFE, 1'b1);
		rd_chk(fcp_pkg::IDX_CYC0, 1'b1, 16'hFCFE, "wide cycle");
		bus_wr(fcp_pkg::IDX_DUTY0, 16'hFDFF, 1'b1);
		bus_wr(fcp_pkg::IDX_SPEED, 16'h0001, 1'b0);
		bus_wr(fcp_pkg::IDX_CTRL_A, 16'h0070, 1'b0);
		repeat (4) @(posedge clk_sys);
		watch(40);
		check("high speed wave", 16'(hi[1]), 16'h0014);
		check("wrap beats match", 16'(hi[0]), 16'h0028);
		$display("test high speed done");
		give_verdict();
	end
endmodule : tb
